/* rtl/fskr_pkg.sv */
package fskr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SPACE_AMP = 8'h63;
    localparam logic [7:0] IDX_SPACE_FREQ = 8'h64;
    localparam logic [7:0] IDX_MARK_AMP = 8'h65;
    localparam logic [7:0] IDX_MARK_FREQ = 8'h66;
    localparam logic [7:0] IDX_S2M_GAIN = 8'h67;
    localparam logic [7:0] IDX_M2S_GAIN = 8'h68;
    localparam logic [7:0] IDX_RELOAD_CTL = 8'h20;
    localparam logic [7:0] IDX_MODE_CTL = 8'h6C;
    localparam logic [7:0] IDX_OSC_AMP = 8'h50;
    localparam logic [7:0] IDX_OSC_FREQ = 8'h51;
    localparam logic [7:0] IDX_OSC_TIMER = 8'h52;
    localparam logic [7:0] IDX_NEXT_SYM = 8'h53;
    localparam logic [7:0] IDX_STATUS = 8'h54;

    // Field positions
    localparam int ENABLE_BIT = 6;
    localparam int STAT_SYM_BIT = 0;
    localparam int STAT_ACT_BIT = 1;

    // Reset values
    localparam logic [15:0] COEF_RST = 16'h0000;
    localparam logic [15:0] TIMER_RST = 16'h0000;
    localparam logic [15:0] GAIN_UNITY = 16'h8000;
    localparam logic [15:0] GAIN_RST = 16'h8000;

    // Gain is unsigned with 15 fraction bits
    localparam int GAIN_FRAC = 15;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {
        SYM_SPACE = 1'b0,
        SYM_MARK = 1'b1
    } fskr_sym_e;

    // Amplitude and frequency travel together
    typedef struct packed {
        logic [15:0] amp;
        logic [15:0] freq;
    } fskr_coef_s;

endpackage

/* rtl/fskr_top.sv */
// The AXI4-Lite slave port is this design's own decision.
module fskr_top import fskr_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [15:0] osc_amplitude,
    output logic [15:0] osc_frequency,
    output logic osc_reload,
    output logic osc_symbol
);

    // Byte lanes 0 and 1 merge into a 16-bit register
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    // Software registers
    fskr_coef_s space_q;
    fskr_coef_s mark_q;
    fskr_coef_s osc_a_q;
    logic [15:0] s2m_gain_q;
    logic [15:0] m2s_gain_q;
    logic [15:0] timer_q;
    logic mode_en_q;
    logic reload_en_q;
    fskr_sym_e next_sym_q;

    // Oscillator state
    logic [15:0] cnt_q;
    fskr_sym_e cur_sym_q;
    logic [15:0] out_amp_q;
    logic [15:0] out_freq_q;
    logic reload_q;

    // Bus slave state
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] aw_idx_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Write channel: address and data latched apart, write done when both held
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Write decode
    wire wr_space_amp = do_write && (aw_idx_q == IDX_SPACE_AMP);
    wire wr_space_freq = do_write && (aw_idx_q == IDX_SPACE_FREQ);
    wire wr_mark_amp = do_write && (aw_idx_q == IDX_MARK_AMP);
    wire wr_mark_freq = do_write && (aw_idx_q == IDX_MARK_FREQ);
    wire wr_s2m = do_write && (aw_idx_q == IDX_S2M_GAIN);
    wire wr_m2s = do_write && (aw_idx_q == IDX_M2S_GAIN);
    wire wr_rel = do_write && (aw_idx_q == IDX_RELOAD_CTL);
    wire wr_mode = do_write && (aw_idx_q == IDX_MODE_CTL);
    wire wr_osc_amp = do_write && (aw_idx_q == IDX_OSC_AMP);
    wire wr_osc_freq = do_write && (aw_idx_q == IDX_OSC_FREQ);
    wire wr_timer = do_write && (aw_idx_q == IDX_OSC_TIMER);
    wire wr_next = do_write && (aw_idx_q == IDX_NEXT_SYM);
    wire wr_hit = wr_space_amp || wr_space_freq || wr_mark_amp || wr_mark_freq
        || wr_s2m || wr_m2s || wr_rel || wr_mode || wr_osc_amp || wr_osc_freq
        || wr_timer || wr_next || (do_write && (aw_idx_q == IDX_STATUS));

    // Address and data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_idx_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_hold_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[9:2];
            end else if (do_write) begin
                aw_hold_q <= 1'b0;
            end
            if (w_fire) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped index answers SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Coefficient registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            space_q <= {COEF_RST, COEF_RST};
            mark_q <= {COEF_RST, COEF_RST};
            osc_a_q <= {COEF_RST, COEF_RST};
            s2m_gain_q <= GAIN_RST;
            m2s_gain_q <= GAIN_RST;
        end else begin
            if (wr_space_amp) space_q.amp <= merge16(space_q.amp, wdata_q, wstrb_q);
            if (wr_space_freq) space_q.freq <= merge16(space_q.freq, wdata_q, wstrb_q);
            if (wr_mark_amp) mark_q.amp <= merge16(mark_q.amp, wdata_q, wstrb_q);
            if (wr_mark_freq) mark_q.freq <= merge16(mark_q.freq, wdata_q, wstrb_q);
            if (wr_osc_amp) osc_a_q.amp <= merge16(osc_a_q.amp, wdata_q, wstrb_q);
            if (wr_osc_freq) osc_a_q.freq <= merge16(osc_a_q.freq, wdata_q, wstrb_q);
            if (wr_s2m) s2m_gain_q <= merge16(s2m_gain_q, wdata_q, wstrb_q);
            if (wr_m2s) m2s_gain_q <= merge16(m2s_gain_q, wdata_q, wstrb_q);
        end
    end

    // Control bits and the symbol that software queues for the next period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_q <= TIMER_RST;
            mode_en_q <= 1'b0;
            reload_en_q <= 1'b0;
            next_sym_q <= SYM_SPACE;
        end else begin
            if (wr_timer) timer_q <= merge16(timer_q, wdata_q, wstrb_q);
            if (wr_mode && wstrb_q[0]) mode_en_q <= wdata_q[ENABLE_BIT];
            if (wr_rel && wstrb_q[0]) reload_en_q <= wdata_q[ENABLE_BIT];
            if (wr_next && wstrb_q[0]) next_sym_q <= fskr_sym_e'(wdata_q[0]);
        end
    end

    // Shift keying only when both enables are set
    wire fsk_on = mode_en_q && reload_en_q;

    // Active timer: period of timer_q cycles, zero stops it
    wire timer_run = (timer_q != 16'h0000);
    wire expire = timer_run && (cnt_q == 16'h0000);
    wire [15:0] cnt_d = expire ? timer_q - 16'h0001 : (timer_run ? cnt_q - 16'h0001 : 16'h0000);

    // Coefficient and gain selection for the coming symbol
    wire is_mark = (next_sym_q == SYM_MARK);
    wire fskr_coef_s sel_coef = is_mark ? mark_q : space_q;
    wire turn = (next_sym_q != cur_sym_q);
    wire [15:0] gain_sel = !turn ? GAIN_UNITY : (is_mark ? s2m_gain_q : m2s_gain_q);
    wire [31:0] prod = sel_coef.amp * gain_sel;
    wire [15:0] scaled_amp = prod[GAIN_FRAC +: 16];

    // Oscillator reload on expiry; normal coefficients when keying is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 16'h0000;
            cur_sym_q <= SYM_SPACE;
            out_amp_q <= COEF_RST;
            out_freq_q <= COEF_RST;
            reload_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            reload_q <= expire;
            if (expire && fsk_on) begin
                out_amp_q <= scaled_amp;
                out_freq_q <= sel_coef.freq;
                cur_sym_q <= next_sym_q;
            end else if (expire) begin
                out_amp_q <= osc_a_q.amp;
                out_freq_q <= osc_a_q.freq;
            end
        end
    end

    assign osc_amplitude = out_amp_q;
    assign osc_frequency = out_freq_q;
    assign osc_reload = reload_q;
    assign osc_symbol = cur_sym_q;

    // Read decode; a read sees the register, status shows live symbol
    wire [7:0] ar_idx = s_axi_araddr[9:2];
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rvalid_q;
    logic [31:0] rd_mux;
    logic rd_hit;

    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        if (ar_idx == IDX_SPACE_AMP) begin
            rd_mux[15:0] = space_q.amp;
        end else if (ar_idx == IDX_SPACE_FREQ) begin
            rd_mux[15:0] = space_q.freq;
        end else if (ar_idx == IDX_MARK_AMP) begin
            rd_mux[15:0] = mark_q.amp;
        end else if (ar_idx == IDX_MARK_FREQ) begin
            rd_mux[15:0] = mark_q.freq;
        end else if (ar_idx == IDX_S2M_GAIN) begin
            rd_mux[15:0] = s2m_gain_q;
        end else if (ar_idx == IDX_M2S_GAIN) begin
            rd_mux[15:0] = m2s_gain_q;
        end else if (ar_idx == IDX_RELOAD_CTL) begin
            rd_mux[ENABLE_BIT] = reload_en_q;
        end else if (ar_idx == IDX_MODE_CTL) begin
            rd_mux[ENABLE_BIT] = mode_en_q;
        end else if (ar_idx == IDX_OSC_AMP) begin
            rd_mux[15:0] = osc_a_q.amp;
        end else if (ar_idx == IDX_OSC_FREQ) begin
            rd_mux[15:0] = osc_a_q.freq;
        end else if (ar_idx == IDX_OSC_TIMER) begin
            rd_mux[15:0] = timer_q;
        end else if (ar_idx == IDX_NEXT_SYM) begin
            rd_mux[0] = next_sym_q;
        end else if (ar_idx == IDX_STATUS) begin
            rd_mux[STAT_SYM_BIT] = cur_sym_q;
            rd_mux[STAT_ACT_BIT] = fsk_on;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read data held until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Checks on the reload path
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_keyed_expiry;
        expire && fsk_on;
    endsequence

    sequence s_reload_pulse;
        osc_reload ##1 !osc_reload;
    endsequence

    a_space_freq_load: assert property (
        s_keyed_expiry and !is_mark |=> osc_frequency == $past(space_q.freq))
        else $error("space frequency not loaded");

    a_mark_freq_load: assert property (
        s_keyed_expiry and is_mark |=> osc_frequency == $past(mark_q.freq))
        else $error("mark frequency not loaded");

    a_space_amp_load: assert property (
        s_keyed_expiry and !is_mark && !turn |=> osc_amplitude == $past(space_q.amp))
        else $error("space amplitude not loaded");

    a_mark_amp_load: assert property (
        s_keyed_expiry and is_mark && !turn |=> osc_amplitude == $past(mark_q.amp))
        else $error("mark amplitude not loaded");

    a_gain_space_mark: assert property (
        s_keyed_expiry and is_mark && turn |-> gain_sel == s2m_gain_q
        ##1 osc_symbol == SYM_MARK
        && osc_amplitude == 16'((32'($past(mark_q.amp)) * $past(s2m_gain_q)) >> GAIN_FRAC))
        else $error("space to mark gain not applied");

    a_gain_mark_space: assert property (
        s_keyed_expiry and !is_mark && turn |-> gain_sel == m2s_gain_q
        ##1 osc_symbol == SYM_SPACE
        && osc_amplitude == 16'((32'($past(space_q.amp)) * $past(m2s_gain_q)) >> GAIN_FRAC))
        else $error("mark to space gain not applied");

    a_keying_off_normal: assert property (
        expire && !(mode_en_q && reload_en_q) |=> osc_amplitude == $past(osc_a_q.amp)
        && osc_frequency == $past(osc_a_q.freq) && osc_symbol == $past(cur_sym_q))
        else $error("normal coefficients not used");

    a_expiry_reload: assert property (
        expire && timer_q > 16'h0001 |=> s_reload_pulse)
        else $error("reload pulse wrong");

    // Amplitude, frequency and symbol only move on an expiry, so the line never sees a half-loaded symbol
    a_outputs_hold: assert property (
        !expire |=> $stable(osc_amplitude) && $stable(osc_frequency) && $stable(osc_symbol))
        else $error("oscillator outputs moved without expiry");

    a_keyed_symbol: assert property (
        s_keyed_expiry |=> osc_symbol == $past(next_sym_q) && osc_reload)
        else $error("keyed symbol not taken");

    a_mode_bit_write: assert property (
        wr_mode && wstrb_q[0] |=> mode_en_q == $past(wdata_q[ENABLE_BIT]))
        else $error("mode enable not written");

    a_reload_bit_write: assert property (
        wr_rel && wstrb_q[0] |=> reload_en_q == $past(wdata_q[ENABLE_BIT]))
        else $error("reload enable not written");

    a_next_sym_write: assert property (
        wr_next && wstrb_q[0] |=> next_sym_q == $past(wdata_q[0]))
        else $error("next symbol not written");

endmodule

/* verification/fskr_host_model.sv */
module fskr_host_model (
    input wire logic aclk,
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    output logic hung
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
    end

    // One word write; stale data is inverted once taken so it is never reused
    task automatic wr(input logic [7:0] idx, input logic [15:0] val, output logic [1:0] resp);
        bit got;
        got = 0;
        resp = 2'h3;
        // One edge between transfers so no strobe is driven twice in a time step
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {16'h0, val};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 64 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                got = 1;
            end
        end
        if (!got) hung <= 1'b1;
    endtask

    // One word read; rready held until the answer is seen
    task automatic rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
        bit got;
        got = 0;
        data = '0;
        resp = 2'h3;
        @(posedge aclk);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 64 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                got = 1;
            end
        end
        if (!got) hung <= 1'b1;
    endtask
endmodule

/* verification/test_fsk_oscillator_reload.sv */
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("wrong value at %0t: got %0h exp %0h", $time, got, exp); \
        end \
    end

module test_fsk_oscillator_reload import fskr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, hung;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, osc_reload, osc_symbol;
    logic [15:0] osc_amplitude, osc_frequency, n_amp, n_freq;
    logic [15:0] coef [6];
    int err_count = 0;
    int cmp_count = 0;
    int prev;
    int seq [6] = '{1, 1, 0, 0, 1, 0};

    fskr_top i_fskr_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_amplitude, .osc_frequency,
        .osc_reload, .osc_symbol);

    fskr_host_model i_fskr_host_model (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hung);

    // Clock and reset
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    end

    // A stuck bus handshake ends the run
    always @(posedge hung) begin
        err_count++;
        conclude();
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Model: gain applies only when the symbol changes
    function automatic logic [15:0] exp_amp(int sym, int prv);
        longint a;
        a = coef[sym * 2];
        if (sym != prv) a = (a * coef[4 + prv]) >> GAIN_FRAC;
        return a[15:0];
    endfunction

    task automatic wreg(logic [7:0] idx, logic [15:0] val);
        i_fskr_host_model.wr(idx, val, resp);
        `CHK(resp, RESP_OKAY)
    endtask

    // Waits for the reload pulse, checks it lasts one cycle, returns after a rising edge
    task automatic wait_reload();
        bit got;
        got = 0;
        for (int n = 0; n < 200 && !got; n++) begin
            @(negedge aclk);
            got = (osc_reload === 1'b1);
        end
        if (!got) begin
            err_count++;
            conclude();
        end else begin
            @(negedge aclk);
            `CHK(osc_reload, 1'b0)
            @(posedge aclk);
        end
    endtask

    task automatic chk_norm(int sym);
        `CHK(osc_amplitude, n_amp)
        `CHK(osc_frequency, n_freq)
        `CHK(osc_symbol, sym[0])
    endtask

    task automatic chk_fsk(int sym, int prv);
        `CHK(osc_amplitude, exp_amp(sym, prv))
        `CHK(osc_frequency, coef[sym * 2 + 1])
        `CHK(osc_symbol, sym[0])
    endtask

    initial begin
        void'($urandom(25471));
        repeat (7) @(posedge aclk);
        // Reset values, random programming and read-back of the six registers
        for (int i = 0; i < 6; i++) begin
            i_fskr_host_model.rd(8'(8'h63 + i), rdat, resp);
            `CHK(rdat, (i < 4) ? 32'h0 : {16'h0, GAIN_RST})
            coef[i] = (i < 4) ? 16'($urandom) : 16'($urandom_range(32'h8000));
            wreg(8'(8'h63 + i), coef[i]);
            i_fskr_host_model.rd(8'(8'h63 + i), rdat, resp);
            `CHK(rdat, {16'h0, coef[i]})
        end
        // Unmapped index refused both ways
        i_fskr_host_model.wr(8'h10, 16'hFFFF, resp);
        `CHK(resp, RESP_SLVERR)
        i_fskr_host_model.rd(8'h10, rdat, resp);
        `CHK({rdat, resp}, {32'h0, RESP_SLVERR})
        // Keying off, then only the mode enable: normal coefficients reload
        n_amp = 16'($urandom);
        n_freq = 16'($urandom);
        wreg(IDX_OSC_AMP, n_amp);
        wreg(IDX_OSC_FREQ, n_freq);
        wreg(IDX_NEXT_SYM, 16'h0001);
        wreg(IDX_OSC_TIMER, 16'h0028);
        wait_reload();
        chk_norm(0);
        wreg(IDX_MODE_CTL, 16'h0040);
        wait_reload();
        chk_norm(0);
        wreg(IDX_NEXT_SYM, 16'h0000);
        wreg(IDX_RELOAD_CTL, 16'h0040);
        // Every transition kind, each with a repeat of the old symbol first
        prev = 0;
        foreach (seq[k]) begin
            wait_reload();
            chk_fsk(prev, prev);
            wreg(IDX_NEXT_SYM, 16'(seq[k]));
            wait_reload();
            chk_fsk(seq[k], prev);
            i_fskr_host_model.rd(IDX_STATUS, rdat, resp);
            `CHK(rdat, {30'h0, 1'b1, 1'(seq[k])})
            prev = seq[k];
        end
        // Reload enable dropped: normal coefficients again, symbol held
        wreg(IDX_RELOAD_CTL, 16'h0000);
        wait_reload();
        chk_norm(prev);
        i_fskr_host_model.rd(IDX_STATUS, rdat, resp);
        `CHK(rdat, {30'h0, 1'b0, 1'(prev)})
        conclude();
    end
endmodule
